// *** src/rsfr_bank.v ***
// command-addressed sequencing and fault register bank with per-output turn-on/off timers
`timescale 1ns/1ps
`include "rsfr_regs.vh"

// Overview of operation
// - global input overcurrent limit, default fifty amperes
// - limit, rise, fall apply only on command
// - host reissues apply after output target change; the bench host never does
// - per-page turn-on delay, ten microsecond units
// - per-page rise time in microseconds
// - per-page turn-off delay, ten microsecond units
// - per-page fall time in microseconds
// - global summary byte covers both outputs
// - bit six set while either output delivers no power
// - bits five, four, three: ov, oc, uv
// - bit two temperature, bit one comm/memory/logic
// - bit zero other change, bit seven zero
module rsfr_bank
(
  // clock and reset
  input wire clk,
  input wire rst,
  // command port: write or read of a command code
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wdata,
  output reg [15:0] cmd_rdata,
  output wire cmd_error,
  // output control and fault inputs; enable, ov and oc carry one bit per output page, the other flags are global
  input wire [1:0] out_enable,
  input wire [1:0] output_overvoltage_flag,
  input wire [1:0] output_overcurrent_flag,
  input wire input_undervoltage_flag,
  input wire temp_fault_flag,
  input wire comm_memory_logic_flag,
  input wire other_status_flag,
  // applied settings and sequencing state
  output reg [15:0] active_iin_oc_limit,
  output wire [1:0] out_ramping_up,
  output wire [1:0] out_ramping_down,
  output wire [1:0] out_power_on
);
  localparam ST_OFF = 3'd0;
  localparam ST_TON_DLY = 3'd1;
  localparam ST_RISE = 3'd2;
  localparam ST_ON = 3'd3;
  localparam ST_TOFF_DLY = 3'd4;
  localparam ST_FALL = 3'd5;
  localparam integer TICK_LAST_INT = `RSFR_TICK_CYCLES - 1;
  localparam integer UNIT_LAST_INT = `RSFR_DELAY_UNIT_US - 1;
  localparam [4:0] TICK_LAST = TICK_LAST_INT[4:0];
  localparam [3:0] UNIT_LAST = UNIT_LAST_INT[3:0];

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  reg page_q;
  reg [15:0] iin_oc_limit_q;
  // per-page settings gathered page by page for the read mux
  wire [31:0] on_dly_all;
  wire [31:0] on_rise_all;
  wire [31:0] off_dly_all;
  wire [31:0] off_fall_all;
  reg [4:0] tick_cnt_q;
  reg tick_q;
  wire [7:0] fault_summary;
  wire known_code;
  wire wr;
  wire apply;

  assign wr = cmd_valid & cmd_write;
  assign apply = wr & (cmd_code == `RSFR_CMD_APPLY);
  assign known_code = (cmd_code == `RSFR_CMD_PAGE) | (cmd_code == `RSFR_CMD_APPLY) |
    (cmd_code == `RSFR_CMD_IIN_OC_LIMIT) | (cmd_code == `RSFR_CMD_TURN_ON_DELAY) |
    (cmd_code == `RSFR_CMD_TURN_ON_RISE) | (cmd_code == `RSFR_CMD_TURN_OFF_DELAY) |
    (cmd_code == `RSFR_CMD_TURN_OFF_FALL) | (cmd_code == `RSFR_CMD_FAULT_SUMMARY);
  // unknown code, or a write to the read-only summary
  assign cmd_error = cmd_valid & (~known_code | (cmd_write & (cmd_code == `RSFR_CMD_FAULT_SUMMARY)));

  // global registers: page select and input overcurrent limit
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      page_q <= 1'b0;
      iin_oc_limit_q <= `RSFR_RST_IIN_OC_LIMIT;
      active_iin_oc_limit <= `RSFR_RST_IIN_OC_LIMIT;
    end
    else
    begin
      if (wr && cmd_code == `RSFR_CMD_PAGE)
        page_q <= cmd_wdata[0];
      if (wr && cmd_code == `RSFR_CMD_IIN_OC_LIMIT)
        iin_oc_limit_q <= cmd_wdata;
      if (apply)
        active_iin_oc_limit <= iin_oc_limit_q;
    end
  end

  // 1 us tick from the 25 MHz clock
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_q <= 5'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 5'h00 : tick_cnt_q + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // per-page registers and sequencer
  // ---------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_page
      reg [15:0] on_dly_q;
      reg [15:0] on_rise_q;
      reg [15:0] off_dly_q;
      reg [15:0] off_fall_q;
      reg [15:0] act_rise_q;
      reg [15:0] act_fall_q;
      reg [2:0] st_q;
      reg [2:0] st_d;
      reg [15:0] cnt_q;
      reg [3:0] unit_q;
      wire sel;
      wire cnt_done;
      wire unit_done;

      assign sel = wr & (page_q == p);
      assign cnt_done = (cnt_q == 16'h0000);
      assign unit_done = (unit_q == 4'h0);
      // publish this page's written settings to the shared read mux
      assign on_dly_all[16*p +: 16] = on_dly_q;
      assign on_rise_all[16*p +: 16] = on_rise_q;
      assign off_dly_all[16*p +: 16] = off_dly_q;
      assign off_fall_all[16*p +: 16] = off_fall_q;

      // paged settings; rise and fall go live only on apply
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          on_dly_q <= `RSFR_RST_TURN_ON_DELAY;
          on_rise_q <= `RSFR_RST_TURN_ON_RISE;
          off_dly_q <= `RSFR_RST_TURN_OFF_DELAY;
          off_fall_q <= `RSFR_RST_TURN_OFF_FALL;
          act_rise_q <= `RSFR_RST_TURN_ON_RISE;
          act_fall_q <= `RSFR_RST_TURN_OFF_FALL;
        end
        else
        begin
          if (sel && cmd_code == `RSFR_CMD_TURN_ON_DELAY)
            on_dly_q <= cmd_wdata;
          if (sel && cmd_code == `RSFR_CMD_TURN_ON_RISE)
            on_rise_q <= cmd_wdata;
          if (sel && cmd_code == `RSFR_CMD_TURN_OFF_DELAY)
            off_dly_q <= cmd_wdata;
          if (sel && cmd_code == `RSFR_CMD_TURN_OFF_FALL)
            off_fall_q <= cmd_wdata;
          if (apply)
          begin
            act_rise_q <= on_rise_q;
            act_fall_q <= off_fall_q;
          end
        end
      end

      // sequencer next state
      always @*
      begin
        st_d = st_q;
        case (st_q)
          ST_OFF:
          begin
            if (out_enable[p])
              st_d = ST_TON_DLY;
          end
          ST_TON_DLY:
          begin
            if (!out_enable[p])
              st_d = ST_OFF;
            else if (tick_q && unit_done && cnt_done)
              st_d = ST_RISE;
          end
          ST_RISE:
          begin
            if (!out_enable[p])
              st_d = ST_TOFF_DLY;
            else if (tick_q && cnt_done)
              st_d = ST_ON;
          end
          ST_ON:
          begin
            if (!out_enable[p])
              st_d = ST_TOFF_DLY;
          end
          ST_TOFF_DLY:
          begin
            if (out_enable[p])
              st_d = ST_TON_DLY;
            else if (tick_q && unit_done && cnt_done)
              st_d = ST_FALL;
          end
          ST_FALL:
          begin
            if (out_enable[p])
              st_d = ST_TON_DLY;
            else if (tick_q && cnt_done)
              st_d = ST_OFF;
          end
          default: st_d = ST_OFF;
        endcase
      end

      // delay counts codes of 10 ticks, ramps count single ticks
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          st_q <= ST_OFF;
          cnt_q <= 16'h0000;
          unit_q <= 4'h0;
        end
        else
        begin
          st_q <= st_d;
          if (st_d != st_q)
          begin
            unit_q <= UNIT_LAST;
            case (st_d)
              ST_TON_DLY: cnt_q <= on_dly_q - 16'h0001;
              ST_RISE: cnt_q <= act_rise_q;
              ST_TOFF_DLY: cnt_q <= off_dly_q - 16'h0001;
              ST_FALL: cnt_q <= act_fall_q;
              default: cnt_q <= 16'h0000;
            endcase
            if ((st_d == ST_TON_DLY && on_dly_q == 16'h0000) ||
                (st_d == ST_TOFF_DLY && off_dly_q == 16'h0000))
            begin
              cnt_q <= 16'h0000;
              unit_q <= 4'h0;
            end
          end
          else if (tick_q)
          begin
            if (st_q == ST_RISE || st_q == ST_FALL)
            begin
              if (!cnt_done)
                cnt_q <= cnt_q - 16'h0001;
            end
            else if (unit_done)
            begin
              unit_q <= UNIT_LAST;
              if (!cnt_done)
                cnt_q <= cnt_q - 16'h0001;
            end
            else
              unit_q <= unit_q - 4'h1;
          end
        end
      end

      assign out_ramping_up[p] = (st_q == ST_RISE);
      assign out_ramping_down[p] = (st_q == ST_FALL);
      assign out_power_on[p] = (st_q == ST_RISE) | (st_q == ST_ON) |
        (st_q == ST_TOFF_DLY) | (st_q == ST_FALL);
    end
  endgenerate

  // ---------------------------------------------------------------
  // fault summary and read data
  // ---------------------------------------------------------------
  assign fault_summary[7] = 1'b0;
  assign fault_summary[`RSFR_SUM_OFF] = ~(&out_power_on);
  assign fault_summary[`RSFR_SUM_VOUT_OV] = |output_overvoltage_flag;
  assign fault_summary[`RSFR_SUM_IOUT_OC] = |output_overcurrent_flag;
  assign fault_summary[`RSFR_SUM_VIN_UV] = input_undervoltage_flag;
  assign fault_summary[`RSFR_SUM_TEMP] = temp_fault_flag;
  assign fault_summary[`RSFR_SUM_COMM] = comm_memory_logic_flag;
  assign fault_summary[`RSFR_SUM_OTHER] = other_status_flag;

  // read data registered one cycle after the request
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      cmd_rdata <= 16'h0000;
    else if (cmd_valid && !cmd_write)
    begin
      case (cmd_code)
        `RSFR_CMD_PAGE: cmd_rdata <= {15'h0000, page_q};
        `RSFR_CMD_IIN_OC_LIMIT: cmd_rdata <= iin_oc_limit_q;
        `RSFR_CMD_TURN_ON_DELAY: cmd_rdata <= on_dly_all[16*page_q +: 16];
        `RSFR_CMD_TURN_ON_RISE: cmd_rdata <= on_rise_all[16*page_q +: 16];
        `RSFR_CMD_TURN_OFF_DELAY: cmd_rdata <= off_dly_all[16*page_q +: 16];
        `RSFR_CMD_TURN_OFF_FALL: cmd_rdata <= off_fall_all[16*page_q +: 16];
        `RSFR_CMD_FAULT_SUMMARY: cmd_rdata <= {8'h00, fault_summary};
        default: cmd_rdata <= 16'h0000;
      endcase
    end
  end
endmodule

// *** src/rsfr_regs.vh ***
// register offsets, reset values, field positions and timing constants of the sequencing register bank
`ifndef RSFR_REGS_VH
`define RSFR_REGS_VH
// command codes
`define RSFR_CMD_IIN_OC_LIMIT 8'h5b
`define RSFR_CMD_TURN_ON_DELAY 8'h60
`define RSFR_CMD_TURN_ON_RISE 8'h61
`define RSFR_CMD_TURN_OFF_DELAY 8'h64
`define RSFR_CMD_TURN_OFF_FALL 8'h65
`define RSFR_CMD_FAULT_SUMMARY 8'h78
`define RSFR_CMD_PAGE 8'h00
`define RSFR_CMD_APPLY 8'he7
// reset values
`define RSFR_RST_IIN_OC_LIMIT 16'h0032
`define RSFR_RST_TURN_ON_DELAY 16'h0014
`define RSFR_RST_TURN_ON_RISE 16'h01f4
`define RSFR_RST_TURN_OFF_DELAY 16'h0000
`define RSFR_RST_TURN_OFF_FALL 16'h01f4
// fault summary bit positions
`define RSFR_SUM_OFF 6
`define RSFR_SUM_VOUT_OV 5
`define RSFR_SUM_IOUT_OC 4
`define RSFR_SUM_VIN_UV 3
`define RSFR_SUM_TEMP 2
`define RSFR_SUM_COMM 1
`define RSFR_SUM_OTHER 0
// timing: clock period in ns, tick period in ns, delay code unit in ticks
`define RSFR_CLK_PERIOD_NS 40
`define RSFR_TICK_NS 1000
`define RSFR_TICK_CYCLES (`RSFR_TICK_NS / `RSFR_CLK_PERIOD_NS)
`define RSFR_DELAY_UNIT_US 10
`endif

// *** test/rsfr_host.sv ***
// management host model issuing one command at a time to the bank
`timescale 1ns/1ps
`include "rsfr_regs.vh"
module rsfr_host
(
  // clock
  input wire clk,
  // command port towards the bank
  output reg cmd_valid,
  output reg cmd_write,
  output reg [7:0] cmd_code,
  output reg [15:0] cmd_wdata,
  input wire [15:0] cmd_rdata,
  input wire cmd_error
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'hff;
    cmd_wdata = 16'hffff;
  end
  // one request: hold everything up to the taking edge, then scramble idle lines
  task xfer(input w, input [7:0] c, input [15:0] d, output [15:0] q, output e);
    begin
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_code <= c;
      cmd_wdata <= d;
      @(posedge clk);
      e = cmd_error;
      cmd_valid <= 1'b0;
      cmd_code <= ~c;
      cmd_wdata <= ~d;
      // read data is registered at the taking edge and stands until the next read
      @(posedge clk);
      q = cmd_rdata;
    end
  endtask
  // apply command; the bench issues it in t_apply and once more at the end of t_paged, never after an enable change
  task apply(output [15:0] q, output e);
    xfer(1'b1, `RSFR_CMD_APPLY, 16'h0000, q, e);
  endtask
endmodule

// *** test/rsfr_bank_properties.sv ***
// port-level checker of the sequencing register bank
`timescale 1ns/1ps
`include "rsfr_regs.vh"
module rsfr_chk
(
  // clock and reset
  input wire clk,
  input wire rst,
  // command port
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_rdata,
  input wire cmd_error,
  // sequencing
  input wire [1:0] out_enable,
  input wire [15:0] active_iin_oc_limit,
  input wire [1:0] out_ramping_up,
  input wire [1:0] out_ramping_down,
  input wire [1:0] out_power_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // read request of the current cycle
  wire rd = cmd_valid && !cmd_write;
  a_summary_read_only: assert property (cmd_valid && cmd_write && cmd_code == `RSFR_CMD_FAULT_SUMMARY |-> cmd_error)
    else $error("summary write not refused");
  a_limit_code_known: assert property (cmd_valid && cmd_code == `RSFR_CMD_IIN_OC_LIMIT |-> !cmd_error)
    else $error("limit command refused");
  a_limit_waits_apply: assert property (!(cmd_valid && cmd_write && cmd_code == `RSFR_CMD_APPLY) |=> $stable(active_iin_oc_limit))
    else $error("applied limit moved without apply");
  a_rdata_holds: assert property (!rd |=> $stable(cmd_rdata))
    else $error("read data changed without read");
  a_summary_off_bit: assert property (rd && cmd_code == `RSFR_CMD_FAULT_SUMMARY |=> cmd_rdata[15:7] == 9'h000 && cmd_rdata[6] == !(&$past(out_power_on)))
    else $error("summary off or unused bits wrong");
  a_on_delay_first: assert property ($rose(out_enable[0]) && !out_power_on[0] |=> !out_ramping_up[0] [*8])
    else $error("output 0 rose without delay");
  a_page1_delay: assert property ($rose(out_enable[1]) && !out_power_on[1] |=> !out_ramping_up[1] [*8])
    else $error("output 1 rose without delay");
  a_ramp_powered: assert property (((out_ramping_up | out_ramping_down) & ~out_power_on) == 2'h0)
    else $error("ramp outside powered phase");
  a_no_power_idle: assert property (!out_enable[0] && !out_power_on[0] |=> !out_power_on[0])
    else $error("output 0 powered without enable");
endmodule
bind rsfr_bank rsfr_chk i_chk (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_code(cmd_code), .cmd_rdata(cmd_rdata), .cmd_error(cmd_error), .out_enable(out_enable),
  .active_iin_oc_limit(active_iin_oc_limit), .out_ramping_up(out_ramping_up),
  .out_ramping_down(out_ramping_down), .out_power_on(out_power_on));

// *** test/rail_sequencing_fault_regs_test.sv ***
// self-checking bench of the sequencing register bank
`timescale 1ns/1ps
`include "rsfr_regs.vh"
`define CHK(n, x, g) begin total_checks++; if ((g) !== (x)) begin errors++; $display("BAD %s exp %h got %h", n, x, g); end end
module rail_sequencing_fault_regs_test;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [1:0] en = 2'h0, ov = 2'h0, oc = 2'h0;
  reg uv = 1'b0, temp = 1'b0, comm = 1'b0, other = 1'b0;
  wire v, w, err;
  wire [7:0] c;
  wire [15:0] d, rdata, act;
  wire [1:0] up, dn, on;
  reg [15:0] q;
  reg e;
  int errors = 0, total_checks = 0, cyc = 0;
  // host model and bank
  rsfr_host i_host (.clk(clk), .cmd_valid(v), .cmd_write(w), .cmd_code(c), .cmd_wdata(d), .cmd_rdata(rdata),
    .cmd_error(err));
  rsfr_bank i_dut (.clk(clk), .rst(rst), .cmd_valid(v), .cmd_write(w), .cmd_code(c), .cmd_wdata(d),
    .cmd_rdata(rdata), .cmd_error(err), .out_enable(en), .output_overvoltage_flag(ov),
    .output_overcurrent_flag(oc), .input_undervoltage_flag(uv), .temp_fault_flag(temp),
    .comm_memory_logic_flag(comm), .other_status_flag(other), .active_iin_oc_limit(act),
    .out_ramping_up(up), .out_ramping_down(dn), .out_power_on(on));
  // clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      close_out;
    end
  end
  task wr(input [7:0] a, input [15:0] x);
    i_host.xfer(1'b1, a, x, q, e);
  endtask
  task rd(input [7:0] a);
    i_host.xfer(1'b0, a, 16'h0000, q, e);
  endtask
  task t_defaults;
    begin
      rd(`RSFR_CMD_IIN_OC_LIMIT);
      `CHK("limit", `RSFR_RST_IIN_OC_LIMIT, q)
      `CHK("active", `RSFR_RST_IIN_OC_LIMIT, act)
      rd(`RSFR_CMD_TURN_ON_DELAY);
      `CHK("on delay", `RSFR_RST_TURN_ON_DELAY, q)
      rd(`RSFR_CMD_TURN_ON_RISE);
      `CHK("rise", `RSFR_RST_TURN_ON_RISE, q)
      rd(`RSFR_CMD_TURN_OFF_DELAY);
      `CHK("off delay", `RSFR_RST_TURN_OFF_DELAY, q)
      rd(`RSFR_CMD_TURN_OFF_FALL);
      `CHK("fall", `RSFR_RST_TURN_OFF_FALL, q)
      $display("t_defaults done");
    end
  endtask
  // limit at its lower bound stays pending until apply
  task t_apply;
    begin
      wr(`RSFR_CMD_IIN_OC_LIMIT, 16'h0000);
      `CHK("pending", `RSFR_RST_IIN_OC_LIMIT, act)
      rd(`RSFR_CMD_IIN_OC_LIMIT);
      `CHK("written", 16'h0000, q)
      i_host.apply(q, e);
      `CHK("applied", 16'h0000, act)
      $display("t_apply done");
    end
  endtask
  // page 1 delay apart from page 0; short ramps on both pages
  task t_paged;
    int i;
    begin
      for (i = 1; i >= 0; i--)
      begin
        wr(`RSFR_CMD_PAGE, i[15:0]);
        wr(`RSFR_CMD_TURN_ON_DELAY, 16'h0001);
        wr(`RSFR_CMD_TURN_ON_RISE, 16'h0005);
        wr(`RSFR_CMD_TURN_OFF_FALL, 16'h0005);
        rd(`RSFR_CMD_TURN_OFF_FALL);
        `CHK("fall", 16'h0005, q)
      end
      wr(`RSFR_CMD_TURN_ON_DELAY, 16'h0014);
      rd(`RSFR_CMD_TURN_ON_DELAY);
      `CHK("page0", 16'h0014, q)
      wr(`RSFR_CMD_PAGE, 16'h0001);
      rd(`RSFR_CMD_TURN_ON_DELAY);
      `CHK("page1", 16'h0001, q)
      wr(`RSFR_CMD_PAGE, 16'h0000);
      wr(`RSFR_CMD_TURN_ON_DELAY, 16'h0001);
      i_host.apply(q, e);
      $display("t_paged done");
    end
  endtask
  // each flag alone, from either output, then none; outputs off
  task t_summary;
    int i;
    begin
      for (i = 0; i < 7; i++)
      begin
        {ov[1], oc[0], uv, temp, comm, other} <= 6'h20 >> i;
        rd(`RSFR_CMD_FAULT_SUMMARY);
        `CHK("summary", {8'h00, 1'b0, 1'b1, 6'h20 >> i}, q)
      end
      `CHK("known", 1'b0, e)
      ov <= 2'h1;
      oc <= 2'h2;
      rd(`RSFR_CMD_FAULT_SUMMARY);
      `CHK("other pages", 16'h0070, q)
      ov <= 2'h0;
      oc <= 2'h0;
      rd(8'h01);
      `CHK("unknown", 1'b1, e)
      wr(`RSFR_CMD_FAULT_SUMMARY, 16'h00ff);
      `CHK("ro", 1'b1, e)
      $display("t_summary done");
    end
  endtask
  // both outputs up with 10 us delay, 5 us rise, then down
  task t_sequence;
    int i;
    begin
      @(posedge clk);
      en <= 2'h3;
      for (i = 0; i < 400 && up[0] !== 1'b1; i++) @(posedge clk);
      `CHK("delay", 1'b1, i >= 220 && i <= 300)
      for (i = 0; i < 400 && up[0] === 1'b1; i++) @(posedge clk);
      `CHK("rise", 1'b1, i >= 100 && i <= 180)
      for (i = 0; i < 400 && (on !== 2'h3 || up !== 2'h0); i++) @(posedge clk);
      rd(`RSFR_CMD_FAULT_SUMMARY);
      `CHK("powered", 1'b0, q[6])
      en <= 2'h0;
      for (i = 0; i < 100 && dn[0] !== 1'b1; i++) @(posedge clk);
      `CHK("off wait", 1'b1, i >= 1 && i <= 30)
      for (i = 0; i < 400 && dn[0] === 1'b1; i++) @(posedge clk);
      `CHK("fall time", 1'b1, i >= 100 && i <= 180)
      for (i = 0; i < 600 && on !== 2'h0; i++) @(posedge clk);
      `CHK("off", 2'h0, on)
      $display("t_sequence done");
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_defaults;
    t_apply;
    t_paged;
    t_summary;
    t_sequence;
    close_out;
  end
endmodule
